// ===== pkg/pdmc_pkg.sv
// pdmc_pkg: constants for the power-down mode controller
// assumes: axi4-lite register access, 125 MHz aclk
package pdmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CSR = 8'h00;
  localparam logic [7:0] OFF_PCFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_STRAPS = 8'h0c;
  // field positions in the cpu control status register
  localparam int PDS_LSB = 10;
  localparam int PDS_MSB = 15;
  localparam int IRQ_GLOBAL_BIT = 0;
  // power_down_select codes
  localparam logic [5:0] PDS_NONE = 6'h00;
  localparam logic [5:0] PDS_HALT_EN = 6'h09;
  localparam logic [5:0] PDS_GATE_ANY = 6'h11;
  localparam logic [5:0] PDS_PLL_OUT = 6'h1a;
  localparam logic [5:0] PDS_PLL_IN = 6'h1c;
  // reset values
  localparam logic [31:0] CSR_RST = 32'h0000_0000;
  localparam logic [7:0] PCFG_RST = 8'h00;
  localparam int PCFG_W = 8;
  // entry delay: up to nine cycles after the selecting write
  localparam int ENTRY_DELAY = 9;
  localparam logic [3:0] ENTRY_CNT = 4'(ENTRY_DELAY - 1);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    PDMC_RUN = 3'b000,
    PDMC_PEND = 3'b001,
    PDMC_HALT = 3'b010,
    PDMC_GATE = 3'b011,
    PDMC_PLLO = 3'b100,
    PDMC_PLLI = 3'b101
  } pdmc_state_t;
endpackage

// ===== src/pdmc_axil.sv
// pdmc_axil: axi4-lite slave, four word registers
// assumes: single clock, one outstanding write and read
`timescale 1ns/1ps
module pdmc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic fire;

  // ----------------------------------------
  // write path
  // ----------------------------------------
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axil_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axil_awaddr;
    end
    if (s_axil_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axil_wdata;
      wstrb_d = s_axil_wstrb;
    end
    fire = aw_have_q && w_have_q && !bvalid_q;
    if (fire) begin
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? pdmc_pkg::RESP_OKAY : pdmc_pkg::RESP_SLVERR;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    if (bvalid_q && s_axil_bready) begin
      bvalid_d = 1'b0;
    end
  end

  assign s_axil_awready = !aw_have_q;
  assign s_axil_wready = !w_have_q;
  assign s_axil_bvalid = bvalid_q;
  assign s_axil_bresp = bresp_q;
  assign wr_en = fire;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axil_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = rd_ok ? rd_data : 32'h0000_0000;
      rresp_d = rd_ok ? pdmc_pkg::RESP_OKAY : pdmc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axil_rready) begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axil_arready = !rvalid_q;
  assign rd_addr = s_axil_araddr;
  assign s_axil_rvalid = rvalid_q;
  assign s_axil_rdata = rdata_q;
  assign s_axil_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule

// ===== src/pdmc_strap.sv
// pdmc_strap: captures peripheral select straps while reset is held
// assumes: strap pins stable during reset
`timescale 1ns/1ps
module pdmc_strap (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] strap_pins,
  output logic [3:0] strap_q
);
  logic [3:0] strap_d;

  // sampled on every clock while in reset, frozen after release
  always_comb begin
    strap_d = aresetn ? strap_q : strap_pins;
  end

  always_ff @(posedge aclk) begin
    strap_q <= strap_d;
  end
endmodule

// ===== src/pdmc_top.sv
// pdmc_top: power-down mode controller with axi4-lite registers
// assumes: cpu, interrupt logic, pll and emulator signals synchronous to aclk
// Operation
// RQ1: mode taken from bits 15..10 of the cpu control register; zero is none
// RQ2: software writes the whole select field in one write
// RQ3: software writes zero to bit 15 of the select field
// RQ4: code 001001 halts cpu, keeps interrupt logic, wakes on enabled interrupt
// RQ5: code 010001 gates cpu clocks, wakes on any interrupt
// RQ6: dma between peripherals and memory keeps running in light mode
// RQ7: code 011010 stops pll output, keeps state, wakes only by reset
// RQ8: code 011100 stops pll input, wakes by reset with pll relock
// RQ9: pll-stopping modes end only at device reset
// RQ10: functional outputs freeze on entry to pll-stopping modes
// RQ11: mode takes effect up to nine cycles after the selecting write
// RQ12: non-enabled interrupt wake resumes at the power-down instruction
// RQ13: enabled interrupt wake runs the service routine, then resumes
// RQ14: service routine runs only if global and nmi enables are set
// RQ15: only the main input clock is gated, other clocks never
// RQ16: attached emulator masks power-down modes until its reset or removal
// RQ17: in pll-stopping modes emulation commands spin and pc writes fail
// RQ18: host port, pci, mac and management enables sampled from reset straps
// RQ19: audio, serial, video and i2c ports enabled by peripheral config bits
// RQ20: selected state held in a register that reset clears to none
`timescale 1ns/1ps
module pdmc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic irq_pending,
  input wire logic irq_enabled,
  input wire logic nmi_enable,
  input wire logic emu_attached,
  input wire logic emu_exec_cmd,
  input wire logic emu_pc_write,
  input wire logic pci_en_pin,
  input wire logic host_data_bit5_strap,
  input wire logic mac_select_pin,
  input wire logic mdio_en_pin,
  output logic cpu_halt,
  output logic main_input_clock_gate,
  output logic pll_output_stop,
  output logic pll_input_stop,
  output logic io_freeze,
  output logic dma_run,
  output logic wake_isr,
  output logic wake_resume,
  output logic emu_spin_idle,
  output logic emu_pc_write_fail,
  output logic host_port_en,
  output logic pci_en,
  output logic ethernet_mac_unit_en,
  output logic mdio_en,
  output logic [pdmc_pkg::PCFG_W-1:0] peripheral_en
);
  logic wr_en;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [3:0] wr_strb;

  logic [3:0] strap_q;
  logic [31:0] csr_q;
  logic [31:0] csr_d;
  logic [31:0] pcfg_word;
  logic [pdmc_pkg::PCFG_W-1:0] pcfg_q;
  logic [pdmc_pkg::PCFG_W-1:0] pcfg_d;

  pdmc_pkg::pdmc_state_t st_q;
  pdmc_pkg::pdmc_state_t st_d;
  logic [5:0] pend_q;
  logic [5:0] pend_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  logic cpu_halt_q;
  logic cpu_halt_d;
  logic clk_gate_q;
  logic clk_gate_d;
  logic pllo_q;
  logic pllo_d;
  logic plli_q;
  logic plli_d;
  logic frz_q;
  logic frz_d;
  logic dma_q;
  logic dma_d;
  logic isr_q;
  logic isr_d;
  logic res_q;
  logic res_d;
  logic spin_q;
  logic spin_d;
  logic pcf_q;
  logic pcf_d;
  logic [pdmc_pkg::PCFG_W-1:0] pen_q;
  logic [pdmc_pkg::PCFG_W-1:0] pen_d;
  logic [3:0] sel_q;

  logic wake_hit;
  logic wake_en_path;

  // ----------------
  // helpers
  // ----------------
  function automatic logic pds_legal(input logic [5:0] code);
    pds_legal = (code == pdmc_pkg::PDS_HALT_EN) || (code == pdmc_pkg::PDS_GATE_ANY) ||
                (code == pdmc_pkg::PDS_PLL_OUT) || (code == pdmc_pkg::PDS_PLL_IN);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------
  // submodules
  // ----------------
  pdmc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // strap order: host port, pci, mac, management
  pdmc_strap u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .strap_pins({mdio_en_pin, mac_select_pin, pci_en_pin, host_data_bit5_strap}),
    .strap_q(strap_q)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  assign wr_ok = (wr_addr == pdmc_pkg::OFF_CSR) || (wr_addr == pdmc_pkg::OFF_PCFG);
  assign rd_ok = (rd_addr == pdmc_pkg::OFF_CSR) || (rd_addr == pdmc_pkg::OFF_PCFG) ||
                 (rd_addr == pdmc_pkg::OFF_STATUS) || (rd_addr == pdmc_pkg::OFF_STRAPS);

  always_comb begin
    csr_d = csr_q;
    pcfg_d = pcfg_q;
    pcfg_word = merge({24'h000000, pcfg_q}, wr_data, wr_strb);
    // whole-field write assumed from software [RQ2] [RQ3]
    if (wr_en && wr_addr == pdmc_pkg::OFF_CSR) begin
      csr_d = merge(csr_q, wr_data, wr_strb);
    end
    if (wr_en && wr_addr == pdmc_pkg::OFF_PCFG) begin
      pcfg_d = pcfg_word[pdmc_pkg::PCFG_W-1:0];
    end
    // field returns to none when the light mode ends by wake
    if (wake_hit) begin
      csr_d[pdmc_pkg::PDS_MSB:pdmc_pkg::PDS_LSB] = pdmc_pkg::PDS_NONE;
    end
  end

  // ----------------
  // read mux
  // ----------------
  always_comb begin
    unique case (rd_addr)
      pdmc_pkg::OFF_CSR: rd_data = csr_q;
      pdmc_pkg::OFF_PCFG: rd_data = {24'h000000, pcfg_q};
      pdmc_pkg::OFF_STATUS: rd_data = {22'h000000, cnt_q, 3'h0, st_q};
      pdmc_pkg::OFF_STRAPS: rd_data = {28'h0000000, strap_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // power-down state machine
  // ----------------------------------------
  assign wake_en_path = irq_pending && irq_enabled;
  assign wake_hit = ((st_q == pdmc_pkg::PDMC_HALT) && wake_en_path) ||
                    ((st_q == pdmc_pkg::PDMC_GATE) && irq_pending);

  always_comb begin
    st_d = st_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    unique case (st_q)
      pdmc_pkg::PDMC_RUN: begin
        // new nonzero legal code arms the entry delay [RQ1] [RQ11]
        if (wr_en && wr_addr == pdmc_pkg::OFF_CSR && wr_strb[1] &&
            pds_legal(wr_data[pdmc_pkg::PDS_MSB:pdmc_pkg::PDS_LSB])) begin
          st_d = pdmc_pkg::PDMC_PEND;
          pend_d = wr_data[pdmc_pkg::PDS_MSB:pdmc_pkg::PDS_LSB];
          cnt_d = pdmc_pkg::ENTRY_CNT;
        end
      end
      pdmc_pkg::PDMC_PEND: begin
        if (emu_attached) begin
          st_d = pdmc_pkg::PDMC_PEND; // masked while emulator attached [RQ16]
        end else if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1; // [RQ11]
        end else begin
          unique case (pend_q)
            pdmc_pkg::PDS_HALT_EN: st_d = pdmc_pkg::PDMC_HALT; // [RQ4]
            pdmc_pkg::PDS_GATE_ANY: st_d = pdmc_pkg::PDMC_GATE; // [RQ5]
            pdmc_pkg::PDS_PLL_OUT: st_d = pdmc_pkg::PDMC_PLLO; // [RQ7]
            default: st_d = pdmc_pkg::PDMC_PLLI; // [RQ8]
          endcase
        end
        if (csr_q[pdmc_pkg::PDS_MSB:pdmc_pkg::PDS_LSB] == pdmc_pkg::PDS_NONE) begin
          st_d = pdmc_pkg::PDMC_RUN;
        end
      end
      pdmc_pkg::PDMC_HALT: begin
        if (wake_en_path) begin
          st_d = pdmc_pkg::PDMC_RUN; // [RQ4]
        end
      end
      pdmc_pkg::PDMC_GATE: begin
        if (irq_pending) begin
          st_d = pdmc_pkg::PDMC_RUN; // [RQ5]
        end
      end
      pdmc_pkg::PDMC_PLLO, pdmc_pkg::PDMC_PLLI: begin
        st_d = st_q; // only reset leaves [RQ9]
      end
      default: st_d = pdmc_pkg::PDMC_RUN;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_comb begin
    cpu_halt_d = (st_d == pdmc_pkg::PDMC_HALT) || (st_d == pdmc_pkg::PDMC_GATE) ||
                 (st_d == pdmc_pkg::PDMC_PLLO) || (st_d == pdmc_pkg::PDMC_PLLI);
    // only the main input clock is gated [RQ15]
    clk_gate_d = (st_d == pdmc_pkg::PDMC_GATE) || (st_d == pdmc_pkg::PDMC_HALT);
    pllo_d = (st_d == pdmc_pkg::PDMC_PLLO); // [RQ7]
    plli_d = (st_d == pdmc_pkg::PDMC_PLLI); // [RQ8]
    frz_d = pllo_d || plli_d; // [RQ10]
    dma_d = !frz_d; // [RQ6]
    // wake routing: isr only with global and nmi enables [RQ12] [RQ13] [RQ14]
    isr_d = (st_q == pdmc_pkg::PDMC_HALT || st_q == pdmc_pkg::PDMC_GATE) && wake_hit &&
            irq_enabled && csr_q[pdmc_pkg::IRQ_GLOBAL_BIT] && nmi_enable;
    res_d = wake_hit && !isr_d;
    spin_d = frz_d && emu_exec_cmd; // [RQ17]
    pcf_d = frz_d && emu_pc_write; // [RQ17]
    pen_d = pcfg_q; // [RQ19]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_q <= pdmc_pkg::CSR_RST; // [RQ20]
      pcfg_q <= pdmc_pkg::PCFG_RST;
      st_q <= pdmc_pkg::PDMC_RUN; // [RQ20]
      pend_q <= pdmc_pkg::PDS_NONE;
      cnt_q <= 4'h0;
      cpu_halt_q <= 1'b0;
      clk_gate_q <= 1'b0;
      pllo_q <= 1'b0;
      plli_q <= 1'b0;
      frz_q <= 1'b0;
      dma_q <= 1'b1;
      isr_q <= 1'b0;
      res_q <= 1'b0;
      spin_q <= 1'b0;
      pcf_q <= 1'b0;
      pen_q <= pdmc_pkg::PCFG_RST;
      sel_q <= 4'h0;
    end else begin
      csr_q <= csr_d;
      pcfg_q <= pcfg_d;
      st_q <= st_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      cpu_halt_q <= cpu_halt_d;
      clk_gate_q <= clk_gate_d;
      pllo_q <= pllo_d;
      plli_q <= plli_d;
      frz_q <= frz_d;
      dma_q <= dma_d;
      isr_q <= isr_d;
      res_q <= res_d;
      spin_q <= spin_d;
      pcf_q <= pcf_d;
      pen_q <= pen_d;
      sel_q <= strap_q; // [RQ18]
    end
  end

  // ----------------
  // port drivers
  // ----------------
  assign cpu_halt = cpu_halt_q;
  assign main_input_clock_gate = clk_gate_q;
  assign pll_output_stop = pllo_q;
  assign pll_input_stop = plli_q;
  assign io_freeze = frz_q;
  assign dma_run = dma_q; // dma keeps going in light mode [RQ6]
  assign wake_isr = isr_q;
  assign wake_resume = res_q;
  assign emu_spin_idle = spin_q;
  assign emu_pc_write_fail = pcf_q;
  assign host_port_en = sel_q[0];
  assign pci_en = sel_q[1];
  assign ethernet_mac_unit_en = sel_q[2];
  assign mdio_en = sel_q[3];
  assign peripheral_en = pen_q;
endmodule

// ===== tb/pdmc_props.sv
// pdmc_props: assertions on the power-down controller top ports
// assumes: bound to pdmc_top, single aclk domain
`timescale 1ns/1ps
module pdmc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_pending,
  input wire logic irq_enabled,
  input wire logic nmi_enable,
  input wire logic emu_attached,
  input wire logic emu_exec_cmd,
  input wire logic emu_pc_write,
  input wire logic cpu_halt,
  input wire logic main_input_clock_gate,
  input wire logic pll_output_stop,
  input wire logic pll_input_stop,
  input wire logic io_freeze,
  input wire logic dma_run,
  input wire logic wake_isr,
  input wire logic wake_resume,
  input wire logic emu_spin_idle,
  input wire logic emu_pc_write_fail
);
  // ----
  // assertions
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic pll_any;
  assign pll_any = pll_output_stop || pll_input_stop;
  pllo_hold_a: assert property (pll_output_stop |=> pll_output_stop)
    else $error("pll output stop left without reset");
  plli_hold_a: assert property (pll_input_stop |=> pll_input_stop)
    else $error("pll input stop left without reset");
  freeze_pll_a: assert property (io_freeze == pll_any)
    else $error("io freeze does not follow pll modes");
  dma_light_a: assert property (main_input_clock_gate |-> dma_run && !io_freeze)
    else $error("dma stopped in light mode");
  halt_any_a: assert property ((main_input_clock_gate || pll_any) |-> cpu_halt)
    else $error("cpu not halted in power-down");
  mode_one_a: assert property ($onehot0({main_input_clock_gate, pll_output_stop, pll_input_stop}))
    else $error("two power-down modes at once");
  wake_pulse_a: assert property ((wake_isr || wake_resume) |->
    !(wake_isr && wake_resume) ##1 !(wake_isr || wake_resume))
    else $error("wake pulse malformed");
  isr_enable_a: assert property (wake_isr |-> $past(nmi_enable) && $past(irq_enabled))
    else $error("service routine without enables");
  wake_cause_a: assert property ((wake_isr || wake_resume) |-> $past(irq_pending))
    else $error("wake without interrupt");
  emu_mask_a: assert property (emu_attached [*2] |-> !$rose(cpu_halt))
    else $error("power-down entered with emulator attached");
  spin_pll_a: assert property (pll_any && emu_exec_cmd |=> emu_spin_idle)
    else $error("emulation command not spun");
  pcw_pll_a: assert property (pll_any && emu_pc_write |=> emu_pc_write_fail)
    else $error("pc write not failed");
  rst_none_a: assert property (disable iff (1'b0) !aresetn |=> !cpu_halt && dma_run)
    else $error("reset did not clear power-down");
  cover property (wake_isr);
  cover property (wake_resume);
  cover property ($rose(pll_input_stop));
endmodule

// ===== tb/pdmc_cpu_model.sv
// pdmc_cpu_model: interrupt source standing for the cpu side
// assumes: irq raised irq_lat+1 cycles after halt, dropped at a wake pulse
`timescale 1ns/1ps
module pdmc_cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_halt,
  input wire logic wake_isr,
  input wire logic wake_resume,
  input wire logic irq_go,
  input wire logic irq_en_cfg,
  input wire logic [3:0] irq_lat,
  output logic irq_pending,
  output logic irq_enabled,
  output logic isr_seen,
  output logic resume_seen
);
  logic [3:0] cnt_q;
  assign irq_enabled = irq_en_cfg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
      irq_pending <= 1'b0;
      isr_seen <= 1'b0;
      resume_seen <= 1'b0;
    end else begin
      if (wake_isr) isr_seen <= 1'b1;
      if (wake_resume) resume_seen <= 1'b1;
      if (wake_isr || wake_resume) irq_pending <= 1'b0;
      else if (irq_go && cpu_halt && !irq_pending) begin
        if (cnt_q == irq_lat) irq_pending <= 1'b1;
        else cnt_q <= cnt_q + 4'h1;
      end else cnt_q <= 4'h0;
    end
  end
endmodule

// ===== tb/power_down_mode_control_tb.sv
// power_down_mode_control_tb: self-checking bench for pdmc_top
// assumes: pdmc_pkg compiled first, checker bound at the foot
`timescale 1ns/1ps
module power_down_mode_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rdat;
  logic [3:0] s_axil_wstrb = 4'h0, irq_lat = 4'h2;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
  logic irq_pending, irq_enabled, isr_seen, resume_seen, irq_go = 1'b0, irq_en_cfg = 1'b0;
  logic nmi_enable = 1'b0, emu_attached = 1'b0, emu_exec_cmd = 1'b0, emu_pc_write = 1'b0;
  logic pci_en_pin = 1'b0, host_data_bit5_strap = 1'b0, mac_select_pin = 1'b0, mdio_en_pin = 1'b0;
  logic cpu_halt, main_input_clock_gate, pll_output_stop, pll_input_stop, io_freeze, dma_run;
  logic wake_isr, wake_resume, emu_spin_idle, emu_pc_write_fail;
  logic host_port_en, pci_en, ethernet_mac_unit_en, mdio_en;
  logic [pdmc_pkg::PCFG_W-1:0] peripheral_en;
  int error_cnt = 0, n_tests = 0;
  typedef struct packed {logic [5:0] code; logic emu; logic [3:0] want;} pdmc_row_t;
  // want: halt, gate, pll out, pll in
  pdmc_row_t rows [7] = '{'{pdmc_pkg::PDS_NONE, 1'b0, 4'b0000},
    '{pdmc_pkg::PDS_HALT_EN, 1'b0, 4'b1100}, '{pdmc_pkg::PDS_GATE_ANY, 1'b0, 4'b1100},
    '{pdmc_pkg::PDS_PLL_OUT, 1'b0, 4'b1010}, '{pdmc_pkg::PDS_PLL_IN, 1'b0, 4'b1001},
    '{6'h12, 1'b0, 4'b0000}, '{pdmc_pkg::PDS_PLL_OUT, 1'b1, 4'b0000}};
  always #4 aclk = ~aclk;
  pdmc_top dut (.*);
  pdmc_cpu_model u_cpu (.*);
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    irq_go <= 1'b0;
    emu_attached <= 1'b0;
    emu_exec_cmd <= 1'b0;
    emu_pc_write <= 1'b0;
    cyc(12);
    aresetn <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_wstrb <= 4'hf;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axil_awvalid && s_axil_awready;
      wh = s_axil_wvalid && s_axil_wready;
      bh = s_axil_bvalid;
      rsp = s_axil_bresp;
      @(posedge aclk);
      if (ah) s_axil_awvalid <= 1'b0;
      if (wh) s_axil_wvalid <= 1'b0;
    end
    s_axil_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axil_arvalid && s_axil_arready;
      rh = s_axil_rvalid;
      rdat = s_axil_rdata;
      rsp = s_axil_rresp;
      @(posedge aclk);
      if (ah) s_axil_arvalid <= 1'b0;
    end
    s_axil_rready <= 1'b0;
  endtask
  task automatic light(input logic [5:0] c, input logic g, en, nm, ei, er, input logic [3:0] lat);
    rst();
    irq_en_cfg <= en;
    nmi_enable <= nm;
    irq_lat <= lat;
    wr(pdmc_pkg::OFF_CSR, {16'h0, c, 9'h0, g});
    cyc(10);
    @(negedge aclk);
    chk("dma_light", dma_run, 1'b1);
    @(posedge aclk);
    irq_go <= 1'b1;
    cyc(24);
    @(negedge aclk);
    chk("isr", isr_seen, ei);
    chk("resume", resume_seen, er);
    chk("halt_after", cpu_halt, !(ei || er));
    rd(pdmc_pkg::OFF_CSR);
    chk("field", rdat[15:10], (ei || er) ? 6'h00 : c);
    $display("light wake %h done", c);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    for (int i = 0; i < 7; i++) begin
      rst();
      emu_attached <= rows[i].emu;
      wr(pdmc_pkg::OFF_CSR, {16'h0, rows[i].code, 10'h0});
      cyc(10);
      @(negedge aclk);
      chk("halt", cpu_halt, rows[i].want[3]);
      chk("gate", main_input_clock_gate, rows[i].want[2]);
      chk("pll_out", pll_output_stop, rows[i].want[1]);
      chk("pll_in", pll_input_stop, rows[i].want[0]);
      chk("freeze", io_freeze, rows[i].want[1] | rows[i].want[0]);
      chk("dma", dma_run, !(rows[i].want[1] | rows[i].want[0]));
      $display("row %0d done", i);
    end
    light(pdmc_pkg::PDS_HALT_EN, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2);
    light(pdmc_pkg::PDS_HALT_EN, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h2);
    light(pdmc_pkg::PDS_HALT_EN, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5);
    light(pdmc_pkg::PDS_HALT_EN, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h2);
    light(pdmc_pkg::PDS_GATE_ANY, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h6);
    light(pdmc_pkg::PDS_GATE_ANY, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
    // pll input stop ignores interrupts, refuses emulation
    rst();
    wr(pdmc_pkg::OFF_CSR, {16'h0, pdmc_pkg::PDS_PLL_IN, 10'h0});
    cyc(10);
    irq_go <= 1'b1;
    emu_exec_cmd <= 1'b1;
    emu_pc_write <= 1'b1;
    cyc(30);
    @(negedge aclk);
    chk("pll_in_held", pll_input_stop, 1'b1);
    chk("spin", emu_spin_idle, 1'b1);
    chk("pc_fail", emu_pc_write_fail, 1'b1);
    $display("pll hold done");
    // straps, config register, refused accesses
    @(posedge aclk);
    host_data_bit5_strap <= 1'b1;
    mac_select_pin <= 1'b1;
    rst();
    cyc(2);
    @(negedge aclk);
    chk("straps", {host_port_en, pci_en, ethernet_mac_unit_en, mdio_en}, 4'b1010);
    chk("pll_clear", pll_input_stop, 1'b0);
    rd(pdmc_pkg::OFF_CSR);
    chk("csr_rst", rdat, pdmc_pkg::CSR_RST);
    wr(pdmc_pkg::OFF_PCFG, 32'h0000_00a5);
    chk("pcfg_resp", rsp, pdmc_pkg::RESP_OKAY);
    cyc(1);
    @(negedge aclk);
    chk("periph", peripheral_en, 8'ha5);
    rd(8'h10);
    chk("unmapped_resp", rsp, pdmc_pkg::RESP_SLVERR);
    chk("unmapped_data", rdat, 32'h0);
    wr(pdmc_pkg::OFF_STRAPS, 32'h0000_000f);
    chk("ro_write", rsp, pdmc_pkg::RESP_SLVERR);
    $display("registers done");
    // emulator masks until removed
    rst();
    emu_attached <= 1'b1;
    wr(pdmc_pkg::OFF_CSR, {16'h0, pdmc_pkg::PDS_PLL_OUT, 10'h0});
    cyc(12);
    @(negedge aclk);
    chk("emu_mask", cpu_halt, 1'b0);
    @(posedge aclk);
    emu_attached <= 1'b0;
    cyc(11);
    @(negedge aclk);
    chk("emu_gone", pll_output_stop, 1'b1);
    $display("emulator done");
    close_out();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
endmodule
bind pdmc_top pdmc_props u_props (.aclk, .aresetn, .irq_pending, .irq_enabled, .nmi_enable,
  .emu_attached, .emu_exec_cmd, .emu_pc_write, .cpu_halt, .main_input_clock_gate,
  .pll_output_stop, .pll_input_stop, .io_freeze, .dma_run, .wake_isr, .wake_resume,
  .emu_spin_idle, .emu_pc_write_fail);
